// [hdl/literal_move_defines.vh]
// Constants for the literal, move and indirect store executor.
// Assumes a 14-bit instruction word and a 32-bit classic Wishbone slave port.
`ifndef LITERAL_MOVE_DEFINES_VH
`define LITERAL_MOVE_DEFINES_VH

// Register byte offsets
`define REG_INSTR      8'h00
`define REG_ACC        8'h04
`define REG_BANK       8'h08
`define REG_PAGE       8'h0c
`define REG_OPTION     8'h10
`define REG_PTR0       8'h14
`define REG_PTR1       8'h18
`define REG_STATUS     8'h1c
`define REG_PC         8'h20
`define REG_PEEK_ADDR  8'h24
`define REG_PEEK_DATA  8'h28
`define REG_EXEC_STAT  8'h2c

// Widths
`define INSTR_W        14
`define ACC_W          8
`define BANK_W         5
`define PAGE_W         7
`define PTR_W          16
`define PC_W           16
`define FILE_W         7
`define MEM_AW         8
`define MEM_DEPTH      256

// Instruction encodings: match when (instr & mask) == pattern
`define ENC_NOP        14'h0000
`define ENC_SOFT_RST   14'h0001
`define ENC_OPTION     14'h0062
`define MSK_BANK       14'h3fe0
`define ENC_BANK       14'h0020
`define MSK_PAGE       14'h3f80
`define ENC_PAGE       14'h3180
`define MSK_ACC_IMM    14'h3f00
`define ENC_ACC_IMM    14'h3000
`define MSK_TO_FILE    14'h3f80
`define ENC_TO_FILE    14'h0080
`define MSK_IND_MODE   14'h3ff8
`define ENC_IND_MODE   14'h0018
`define MSK_IND_REL    14'h3f80
`define ENC_IND_REL    14'h3f80

// Operand fields
`define F_MM_LO        0
`define F_MM_HI        1
`define F_SEL_MM       2
`define F_SEL_REL      6
`define F_REL_HI       5
`define F_FILE_HI      6

// Pointer update codes
`define MM_PRE_INC     2'h0
`define MM_PRE_DEC     2'h1
`define MM_POST_INC    2'h2
`define MM_POST_DEC    2'h3

// File addresses that are the virtual indirect ports
`define FILE_VPORT0    7'h00
`define FILE_VPORT1    7'h01

// Reset values
`define RST_ACC        8'h00
`define RST_BANK       5'h00
`define RST_PAGE       7'h00
`define RST_OPTION     8'hff
`define RST_PTR        16'h0000
`define RST_STATUS     8'h18
`define RST_PC         16'h0000

// Exec status bits
`define EX_UNKNOWN     0
`define EX_SOFT_RST    1

`endif

// [hdl/data_ram.v]
// Data memory: one write port, one read port with registered read data.
// Assumes writer and reader share clk_i; no reset on the array.
`timescale 1ns/1ps
`default_nettype none
`include "literal_move_defines.vh"

module data_ram (
	input  wire                  clk_i,
	input  wire                  we_i,
	input  wire [`MEM_AW-1:0]    waddr_i,
	input  wire [`ACC_W-1:0]     wdata_i,
	input  wire [`MEM_AW-1:0]    raddr_i,
	output reg  [`ACC_W-1:0]     rdata_o
);

	reg [`ACC_W-1:0] mem_ff [0:`MEM_DEPTH-1];

	always @(posedge clk_i) begin
		if (we_i) begin
			mem_ff[waddr_i] <= wdata_i;
		end
		rdata_o <= mem_ff[raddr_i];
	end

endmodule // data_ram
`default_nettype wire

// [hdl/literal_move_indirect_exec.v]
// Executes literal loads, accumulator stores and indirect stores.
// Assumes a classic Wishbone master; one instruction per write to the
// instruction register, one instruction cycle per accepted write.
// Behaviour
// - Bank literal loads selector, flags untouched
// - Page literal loads upper latch, flags untouched
// - Accumulator literal load, one cycle, no flags
// - Accumulator stored to banked file register
// - Indirect store picks pointer by index
// - Effective address: pointer +1, -1, unchanged (post modes) or plus signed offset
// - Pointer post-value: +1, -1 or unchanged
// - Update code 00 pre-inc ... 11 post-dec
// - Virtual indirect ports redirect through pointer
// - Pointers wrap modulo sixteen bits
// - Indirect store and pointer steps keep flags
// - Option load copies accumulator
// - Software reset clears core state one cycle later; exec status flags are kept
`timescale 1ns/1ps
`default_nettype none
`include "literal_move_defines.vh"

module literal_move_indirect_exec (
	input  wire                  clk_i,
	input  wire                  rst_i,
	input  wire                  cyc_i,
	input  wire                  stb_i,
	input  wire                  we_i,
	input  wire [7:0]            adr_i,
	input  wire [3:0]            sel_i,
	input  wire [31:0]           dat_i,
	output reg  [31:0]           dat_o,
	output wire                  ack_o,
	output reg                   soft_reset_o,
	output wire [`BANK_W-1:0]    bank_selector_o,
	output wire [`PAGE_W-1:0]    pc_upper_latch_o,
	output wire [`ACC_W-1:0]     option_o
);

	////////////////////////////////////////////////////////////////////////
	// Decoded operation codes
	localparam [3:0] OP_NOP      = 4'h0;
	localparam [3:0] OP_BANK     = 4'h1;
	localparam [3:0] OP_PAGE     = 4'h2;
	localparam [3:0] OP_ACC_IMM  = 4'h3;
	localparam [3:0] OP_TO_FILE  = 4'h4;
	localparam [3:0] OP_IND_MODE = 4'h5;
	localparam [3:0] OP_IND_REL  = 4'h6;
	localparam [3:0] OP_OPTION   = 4'h7;
	localparam [3:0] OP_SOFT_RST = 4'h8;
	localparam [3:0] OP_UNKNOWN  = 4'h9;

	function [3:0] decode;
		input [`INSTR_W-1:0] ins;
		begin
			if (ins == `ENC_NOP)
				decode = OP_NOP;
			else if (ins == `ENC_SOFT_RST)
				decode = OP_SOFT_RST;
			else if (ins == `ENC_OPTION)
				decode = OP_OPTION;
			else if ((ins & `MSK_BANK) == `ENC_BANK)
				decode = OP_BANK;
			else if ((ins & `MSK_PAGE) == `ENC_PAGE)
				decode = OP_PAGE;
			else if ((ins & `MSK_ACC_IMM) == `ENC_ACC_IMM)
				decode = OP_ACC_IMM;
			else if ((ins & `MSK_TO_FILE) == `ENC_TO_FILE)
				decode = OP_TO_FILE;
			else if ((ins & `MSK_IND_MODE) == `ENC_IND_MODE)
				decode = OP_IND_MODE;
			else if ((ins & `MSK_IND_REL) == `ENC_IND_REL)
				decode = OP_IND_REL;
			else
				decode = OP_UNKNOWN;
		end
	endfunction

	// Step a pointer by one; the 16-bit width gives the wrap for free
	function [`PTR_W-1:0] ptr_step;
		input [`PTR_W-1:0] p;
		input              down;
		begin
			if (down)
				ptr_step = p - 16'h0001;
			else
				ptr_step = p + 16'h0001;
		end
	endfunction

	// Register address match, used by the instruction and exec status write decoders
	function reg_hit;
		input [7:0] adr;
		input [7:0] offs;
		begin
			reg_hit = (adr == offs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// State
	reg  [`INSTR_W-1:0] instr_ff;
	reg  [`ACC_W-1:0]   acc_ff;
	reg  [`BANK_W-1:0]  bank_selector_ff;
	reg  [`PAGE_W-1:0]  pc_upper_latch_ff;
	reg  [`ACC_W-1:0]   option_ff;
	// Pointers are bus-writable so software can seed them
	reg  [`PTR_W-1:0]   indirect_pointer0_ff;
	reg  [`PTR_W-1:0]   indirect_pointer1_ff;
	reg  [`ACC_W-1:0]   status_ff;
	reg  [`PC_W-1:0]    pc_ff;
	reg  [`MEM_AW-1:0]  peek_addr_ff;
	reg  [1:0]          exec_stat_ff;
	reg                 ack_ff;

	reg  [`ACC_W-1:0]   nxt_acc;
	reg  [`BANK_W-1:0]  nxt_bank_selector;
	reg  [`PAGE_W-1:0]  nxt_pc_upper_latch;
	reg  [`ACC_W-1:0]   nxt_option;
	reg  [`PTR_W-1:0]   nxt_ptr0;
	reg  [`PTR_W-1:0]   nxt_ptr1;
	reg  [`PTR_W-1:0]   eff_addr;
	reg                 mem_we;
	reg                 nxt_soft_reset;
	reg                 unknown_hit;
	reg  [1:0]          nxt_exec_stat;
	reg  [31:0]         nxt_dat;

	wire [`ACC_W-1:0]   peek_data;
	wire [`INSTR_W-1:0] new_instr = dat_i[`INSTR_W-1:0];
	wire [3:0]          op        = decode(new_instr);
	wire [`PTR_W-1:0]   sel_ptr;
	wire [`PTR_W-1:0]   rel_off;
	wire                ind_sel;
	wire [1:0]          mm_code;
	wire [`FILE_W-1:0]  file_addr;

	////////////////////////////////////////////////////////////////////////
	// Wishbone slave: ack one cycle after the request, writes at that edge
	wire req      = cyc_i & stb_i;
	wire wr_edge  = req & ack_ff & we_i;
	// A narrow write to the instruction register is ignored, not executed
	wire exec_go  = wr_edge & reg_hit(adr_i, `REG_INSTR) & (&sel_i[1:0]);
	// Soft reset reuses the reset path one cycle after the instruction
	wire any_reset = rst_i | soft_reset_o;

	// Soft reset leaves ack_ff alone so an open bus cycle still ends
	assign ack_o = ack_ff & req;

	always @(posedge clk_i) begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= req & ~ack_ff;
	end

	////////////////////////////////////////////////////////////////////////
	// Indirect store operand selection
	assign ind_sel   = (op == OP_IND_REL) ? new_instr[`F_SEL_REL] : new_instr[`F_SEL_MM];
	assign sel_ptr   = ind_sel ? indirect_pointer1_ff : indirect_pointer0_ff;
	// Relative offset is sign-extended from the six-bit field
	assign rel_off   = {{(`PTR_W-`F_REL_HI-1){new_instr[`F_REL_HI]}}, new_instr[`F_REL_HI:0]};
	assign mm_code   = new_instr[`F_MM_HI:`F_MM_LO];
	assign file_addr = new_instr[`F_FILE_HI:0];

	////////////////////////////////////////////////////////////////////////
	// Execute
	always @* begin
		nxt_acc            = acc_ff;
		nxt_bank_selector  = bank_selector_ff;
		nxt_pc_upper_latch = pc_upper_latch_ff;
		nxt_option         = option_ff;
		nxt_ptr0           = indirect_pointer0_ff;
		nxt_ptr1           = indirect_pointer1_ff;
		eff_addr           = {`PTR_W{1'b0}};
		mem_we             = 1'b0;
		nxt_soft_reset     = 1'b0;
		unknown_hit        = 1'b0;
		if (exec_go) begin
			case (op)
			OP_BANK: begin
				nxt_bank_selector = new_instr[`BANK_W-1:0];
			end
			OP_PAGE: begin
				nxt_pc_upper_latch = new_instr[`PAGE_W-1:0];
			end
			OP_ACC_IMM: begin
				nxt_acc = new_instr[`ACC_W-1:0];
			end
			OP_TO_FILE: begin
				mem_we = 1'b1;
				// Only the low bank bit reaches the 256-byte array
				if (file_addr == `FILE_VPORT0)
					eff_addr = indirect_pointer0_ff;
				else if (file_addr == `FILE_VPORT1)
					eff_addr = indirect_pointer1_ff;
				else
					eff_addr = {{(`PTR_W-`BANK_W-`FILE_W){1'b0}}, bank_selector_ff, file_addr};
			end
			OP_IND_MODE: begin
				mem_we = 1'b1;
				// Post modes store at the old pointer, pre modes at the stepped one
				case (mm_code)
				`MM_PRE_INC:  eff_addr = ptr_step(sel_ptr, 1'b0);
				`MM_PRE_DEC:  eff_addr = ptr_step(sel_ptr, 1'b1);
				`MM_POST_INC: eff_addr = sel_ptr;
				default:      eff_addr = sel_ptr;
				endcase
				// Both increments step up, both decrements step down
				if (ind_sel)
					nxt_ptr1 = ptr_step(sel_ptr, mm_code[0]);
				else
					nxt_ptr0 = ptr_step(sel_ptr, mm_code[0]);
			end
			OP_IND_REL: begin
				mem_we   = 1'b1;
				eff_addr = sel_ptr + rel_off;
			end
			OP_OPTION: begin
				nxt_option = acc_ff;
			end
			OP_SOFT_RST: begin
				nxt_soft_reset = 1'b1;
			end
			OP_NOP: begin
				nxt_acc = acc_ff;
			end
			default: begin
				// Unknown words are flagged and still advance the program counter
				unknown_hit = 1'b1;
			end
			endcase
		end
	end

	// Status flags are owned by software; no instruction writes them except soft reset, which reloads RST_STATUS
	always @(posedge clk_i) begin
		if (any_reset) begin
			instr_ff             <= {`INSTR_W{1'b0}};
			acc_ff               <= `RST_ACC;
			bank_selector_ff     <= `RST_BANK;
			pc_upper_latch_ff    <= `RST_PAGE;
			option_ff            <= `RST_OPTION;
			indirect_pointer0_ff <= `RST_PTR;
			indirect_pointer1_ff <= `RST_PTR;
			status_ff            <= `RST_STATUS;
			pc_ff                <= `RST_PC;
			peek_addr_ff         <= {`MEM_AW{1'b0}};
		end else begin
			acc_ff               <= nxt_acc;
			bank_selector_ff     <= nxt_bank_selector;
			pc_upper_latch_ff    <= nxt_pc_upper_latch;
			option_ff            <= nxt_option;
			indirect_pointer0_ff <= nxt_ptr0;
			indirect_pointer1_ff <= nxt_ptr1;
			if (exec_go) begin
				instr_ff <= new_instr;
				pc_ff    <= pc_ff + 16'h0001;
			end
			if (wr_edge) begin
				case (adr_i)
				`REG_ACC:       acc_ff               <= dat_i[`ACC_W-1:0];
				`REG_PTR0:      indirect_pointer0_ff <= dat_i[`PTR_W-1:0];
				`REG_PTR1:      indirect_pointer1_ff <= dat_i[`PTR_W-1:0];
				`REG_STATUS:    status_ff            <= dat_i[`ACC_W-1:0];
				`REG_PEEK_ADDR: peek_addr_ff         <= dat_i[`MEM_AW-1:0];
				default:        peek_addr_ff         <= peek_addr_ff;
				endcase
			end
		end
	end

	// Soft reset pulse lasts one cycle, then clears the core state itself
	always @(posedge clk_i) begin
		if (rst_i)
			soft_reset_o <= 1'b0;
		else
			soft_reset_o <= nxt_soft_reset;
	end

	// Sticky exec flags, write one to clear; a new event beats the clear
	always @* begin
		nxt_exec_stat = exec_stat_ff;
		if (wr_edge && reg_hit(adr_i, `REG_EXEC_STAT))
			nxt_exec_stat = exec_stat_ff & ~dat_i[1:0];
		if (unknown_hit)
			nxt_exec_stat[`EX_UNKNOWN] = 1'b1;
		if (soft_reset_o)
			nxt_exec_stat[`EX_SOFT_RST] = 1'b1;
	end

	// Soft reset does not clear these, so software can still see why it happened
	always @(posedge clk_i) begin
		if (rst_i)
			exec_stat_ff <= 2'b00;
		else
			exec_stat_ff <= nxt_exec_stat;
	end

	////////////////////////////////////////////////////////////////////////
	// Data memory: only the low address bits reach the array, so pointers
	// beyond the array alias onto it
	data_ram i_data_ram (
		.clk_i   (clk_i),
		.we_i    (mem_we),
		.waddr_i (eff_addr[`MEM_AW-1:0]),
		.wdata_i (acc_ff),
		.raddr_i (peek_addr_ff),
		.rdata_o (peek_data)
	);

	////////////////////////////////////////////////////////////////////////
	// Read data, registered in the request's first cycle so that it
	// stands through the acknowledged cycle
	always @* begin
		case (adr_i)
		`REG_INSTR:     nxt_dat = {{(32-`INSTR_W){1'b0}}, instr_ff};
		`REG_ACC:       nxt_dat = {{(32-`ACC_W){1'b0}}, acc_ff};
		`REG_BANK:      nxt_dat = {{(32-`BANK_W){1'b0}}, bank_selector_ff};
		`REG_PAGE:      nxt_dat = {{(32-`PAGE_W){1'b0}}, pc_upper_latch_ff};
		`REG_OPTION:    nxt_dat = {{(32-`ACC_W){1'b0}}, option_ff};
		`REG_PTR0:      nxt_dat = {{(32-`PTR_W){1'b0}}, indirect_pointer0_ff};
		`REG_PTR1:      nxt_dat = {{(32-`PTR_W){1'b0}}, indirect_pointer1_ff};
		`REG_STATUS:    nxt_dat = {{(32-`ACC_W){1'b0}}, status_ff};
		`REG_PC:        nxt_dat = {{(32-`PC_W){1'b0}}, pc_ff};
		`REG_PEEK_ADDR: nxt_dat = {{(32-`MEM_AW){1'b0}}, peek_addr_ff};
		`REG_PEEK_DATA: nxt_dat = {{(32-`ACC_W){1'b0}}, peek_data};
		`REG_EXEC_STAT: nxt_dat = {{30{1'b0}}, exec_stat_ff};
		default:        nxt_dat = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i)
			dat_o <= 32'h0000_0000;
		else if (req && !ack_ff)
			dat_o <= nxt_dat;
	end

	assign bank_selector_o  = bank_selector_ff;
	assign pc_upper_latch_o = pc_upper_latch_ff;
	assign option_o         = option_ff;

endmodule // literal_move_indirect_exec
`default_nettype wire

// [verification/literal_move_assertions.sv]
// Assertions on the ports of the literal, move and indirect store executor.
// Assumes one clock, synchronous active-high reset, classic Wishbone slave.
`timescale 1ns/1ps
`default_nettype none
`include "literal_move_defines.vh"
module literal_move_assertions (
	input wire logic                 clk_i,
	input wire logic                 rst_i,
	input wire logic                 cyc_i,
	input wire logic                 stb_i,
	input wire logic                 we_i,
	input wire logic [7:0]           adr_i,
	input wire logic [3:0]           sel_i,
	input wire logic [31:0]          dat_i,
	input wire logic [31:0]          dat_o,
	input wire logic                 ack_o,
	input wire logic                 soft_reset_o,
	input wire logic [`BANK_W-1:0]   bank_selector_o,
	input wire logic [`PAGE_W-1:0]   pc_upper_latch_o,
	input wire logic [`ACC_W-1:0]    option_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Instruction accepted at this edge
	wire logic                ex = cyc_i & stb_i & we_i & ack_o & (adr_i == 8'h00) & (sel_i[1:0] == 2'b11);
	wire logic [13:0]         ins = dat_i[13:0];
	a_bank_load: assert property (ex && (ins & `MSK_BANK) == `ENC_BANK |=> bank_selector_o == $past(dat_i[4:0]))
		else $error("bank selector not loaded");
	a_bank_keeps: assert property (ex && (ins & `MSK_BANK) == `ENC_BANK |=> $stable(pc_upper_latch_o) && $stable(option_o))
		else $error("bank load touched other state");
	a_page_load: assert property (ex && (ins & `MSK_PAGE) == `ENC_PAGE |=> pc_upper_latch_o == $past(dat_i[6:0]))
		else $error("upper latch not loaded");
	a_page_keeps: assert property (ex && (ins & `MSK_PAGE) == `ENC_PAGE |=>
		$stable(bank_selector_o) && $stable(option_o))
		else $error("page load touched other state");
	a_nop_keeps: assert property (ex && ins == `ENC_NOP |=> $stable(bank_selector_o) && $stable(pc_upper_latch_o) && $stable(option_o))
		else $error("no-operation changed state");
	a_soft_pulse: assert property (ex && ins == `ENC_SOFT_RST |=> soft_reset_o ##1 !soft_reset_o)
		else $error("soft reset pulse wrong");
	a_soft_clears: assert property (soft_reset_o |=> bank_selector_o == 5'h00 && pc_upper_latch_o == 7'h00 && option_o == 8'hff)
		else $error("soft reset left state");
	a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
		else $error("ack timing wrong");
	a_unmapped_zero: assert property (ack_o && !we_i && adr_i == 8'h30 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
endmodule // literal_move_assertions
bind literal_move_indirect_exec literal_move_assertions i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
	.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.soft_reset_o(soft_reset_o), .bank_selector_o(bank_selector_o), .pc_upper_latch_o(pc_upper_latch_o),
	.option_o(option_o));
`default_nettype wire

// [verification/testbench.sv]
// Self-checking bench: instructions and register accesses over Wishbone.
// Assumes the executor's register map and encodings from the defines header.
`timescale 1ns/1ps
`default_nettype none
`include "literal_move_defines.vh"
module testbench;
	logic                clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0]          adr = 8'h00;
	logic [3:0]          sel = 4'hf;
	logic [31:0]         dat = 32'h0000_0000, dat_o, rv;
	logic                ack_o, soft_reset_o;
	logic [4:0]          bank;
	logic [6:0]          page;
	logic [7:0]          opt;
	int                  n_errors = 0, n_compared = 0, n_instr = 0;
	literal_move_indirect_exec i_literal_move_indirect_exec (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
		.soft_reset_o(soft_reset_o), .bank_selector_o(bank), .pc_upper_latch_o(page), .option_o(opt));
	initial begin
		forever #25 clk_i = ~clk_i;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	// One classic cycle, entered just after a rising edge; ack and read data
	// are sampled at the rising edge, then one idle cycle follows
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int   n;
		logic got;
		n = 0;
		cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		got = (ack_o === 1'b1);
		rv = dat_o;
		cyc <= 0; stb <= 0; we <= 0;
		@(posedge clk_i);
		if (!got) begin
			n_errors++;
			$display("mismatch at %0t: no acknowledge", $time);
			end_sim();
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(0, a, 32'h0000_0000);
		chk(rv, e);
	endtask
	task automatic x(input logic [13:0] i);
		n_instr++;
		bus(1, `REG_INSTR, {18'h0_0000, i});
	endtask
	task automatic mem(input logic [7:0] a, input logic [7:0] e);
		bus(1, `REG_PEEK_ADDR, {24'h00_0000, a});
		rd(`REG_PEEK_DATA, {24'h00_0000, e});
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [1:0] m;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk({bank, page, opt}, {5'h00, 7'h00, 8'hff});
		rd(8'h30, 32'h0000_0000);
		x(`ENC_BANK | 14'h000f); chk(bank, 5'h0f);
		x(`ENC_PAGE | 14'h007f); chk(page, 7'h7f);
		x(`ENC_ACC_IMM | 14'h00a5); rd(`REG_ACC, 32'h0000_00a5);
		x(`ENC_BANK | 14'h0001); x(`ENC_TO_FILE | 14'h0005); mem(8'h85, 8'ha5);
		x(`ENC_OPTION); chk(opt, 8'ha5);
		sel <= 4'h0;
		bus(1, `REG_INSTR, {18'h0_0000, `ENC_ACC_IMM | 14'h0077});
		sel <= 4'hf;
		rd(`REG_ACC, 32'h0000_00a5); rd(`REG_OPTION, 32'h0000_00a5);
		$display("test literals done");
		for (int i = 0; i < 4; i++) begin
			m = i[1:0];
			bus(1, `REG_PTR1, 32'h0000_0000);
			x(`ENC_ACC_IMM | (14'h0010 + i[13:0]));
			x(`ENC_IND_MODE | 14'h0004 | {12'h000, m});
			rd(`REG_PTR1, m[0] ? 32'h0000_ffff : 32'h0000_0001);
			mem(m[1] ? 8'h00 : (m[0] ? 8'hff : 8'h01), 8'h10 + i[7:0]);
		end
		bus(1, `REG_PTR0, 32'h0000_ffff);
		x(`ENC_IND_MODE | 14'h0002); rd(`REG_PTR0, 32'h0000_0000); mem(8'hff, 8'h13);
		bus(1, `REG_PTR0, 32'h0000_0040);
		x(`ENC_IND_REL | 14'h0020); rd(`REG_PTR0, 32'h0000_0040); mem(8'h20, 8'h13);
		bus(1, `REG_PTR1, 32'h0000_0033);
		x(`ENC_TO_FILE | 14'h0001); mem(8'h33, 8'h13); rd(`REG_PTR1, 32'h0000_0033);
		rd(`REG_STATUS, 32'h0000_0018);
		$display("test indirect done");
		rd(`REG_PC, n_instr);
		x(`ENC_NOP); rd(`REG_PC, n_instr); rd(`REG_ACC, 32'h0000_0013);
		$display("test nop done");
		x(`ENC_SOFT_RST); @(posedge clk_i);
		chk({bank, page, opt}, {5'h00, 7'h00, 8'hff}); rd(`REG_ACC, 32'h0000_0000);
		rd(`REG_PC, 32'h0000_0000); rd(`REG_PTR1, 32'h0000_0000); rd(`REG_STATUS, 32'h0000_0018);
		rd(`REG_EXEC_STAT, 32'h0000_0002);
		$display("test soft reset done");
		x(14'h0002); rd(`REG_EXEC_STAT, 32'h0000_0003);
		bus(1, `REG_EXEC_STAT, 32'h0000_0001); rd(`REG_EXEC_STAT, 32'h0000_0002);
		x(`ENC_BANK | 14'h0003); chk(bank, 5'h03);
		x(14'h0002);
		rst_i <= 1;
		@(posedge clk_i);
		rst_i <= 0;
		@(posedge clk_i);
		chk(bank, 5'h00); rd(`REG_EXEC_STAT, 32'h0000_0000);
		$display("test exec status done");
		end_sim();
	end
endmodule // testbench
`default_nettype wire
